// file: hdl/rcs_reader_config_regs.sv
`timescale 1ns/1ps
`include "rcs_cfg.svh"

module rcs_reader_config_regs (
    // Clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RESET,
    // APB slave
    input  wire rcs_pkg::rcs_apb_req_t APB_REQ,
    output rcs_pkg::rcs_apb_rsp_t      APB_RSP,
    // Checksum engine
    input  wire logic                 CSUM_LOAD,
    input  wire logic [15:0]          CSUM_VALUE,
    output logic                      CHECKSUM_DONE_FLAG,
    // Framing: parity path
    input  wire logic                 TX_PARITY_IN,
    output logic                      TX_PARITY_EN,
    output logic                      TX_PARITY_OUT,
    input  wire logic                 RX_PARITY_BIT,
    input  wire logic                 RX_PARITY_STROBE,
    input  wire logic                 RX_PARITY_EXPECT,
    output logic                      RX_PARITY_ERROR,
    output logic                      RX_EXTRA_DATA_VALID,
    output logic                      RX_EXTRA_DATA_BIT,
    // Modulator
    input  wire logic                 MOD_START,
    output logic                      MOD_PULSE,
    // Configuration to consumers
    output rcs_pkg::rcs_cfg_out_t      CFG_OUT
);
    import rcs_pkg::*;

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [1:0]  wait_q;
    logic [1:0]  wait_d;
    logic        bypass_q;
    logic        bypass_d;
    logic [7:0]  baud_q;
    logic [7:0]  baud_d;
    logic [7:0]  width_q;
    logic [7:0]  width_d;
    logic [15:0] csum_q;
    logic [15:0] csum_d;
    logic        done_q;
    logic        done_d;
    logic [3:0]  total_q;
    logic [3:0]  total_d;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic        acc;
    logic        wr;
    logic        addr_ok;
    logic [7:0]  idx;
    logic [7:0]  wbyte;
    logic [7:0]  rbyte;
    logic        hit;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        err_q;
    logic        err_d;
    logic        ack_q;
    logic        ack_d;

    assign idx     = APB_REQ.paddr[9:2];
    assign addr_ok = (APB_REQ.paddr[1:0] == 2'h0);
    assign wbyte   = APB_REQ.pwdata[7:0];
    // Setup cycle registers the answer; access phase completes one cycle later
    assign acc     = APB_REQ.psel && !APB_REQ.penable;
    // Writes land only at the access edge, where the master sees pready
    assign wr      = APB_REQ.psel && APB_REQ.penable && ack_q && APB_REQ.pwrite && addr_ok;

    always_comb begin
        hit   = addr_ok;
        rbyte = 8'h00;
        unique case (idx)
            `RCS_IDX_RESP_WAIT: rbyte = {`RCS_RST_WAIT_RSVD, wait_q};
            `RCS_IDX_PARITY:    rbyte = {3'h0, bypass_q, 4'h0};
            `RCS_IDX_RSVD_A:    rbyte = `RCS_RST_RSVD_A;
            `RCS_IDX_BAUD:      rbyte = baud_q;
            `RCS_IDX_RSVD_B:    rbyte = `RCS_RST_RSVD_B;
            `RCS_IDX_CSUM_HIGH: rbyte = csum_q[15:8];
            `RCS_IDX_CSUM_LOW:  rbyte = csum_q[7:0];
            `RCS_IDX_RSVD_C:    rbyte = `RCS_RST_RSVD_C;
            `RCS_IDX_MOD_WIDTH: rbyte = width_q;
            `RCS_IDX_RSVD_D:    rbyte = `RCS_RST_RSVD_D;
            default:            hit   = 1'b0;
        endcase
    end

    always_comb begin
        rdata_d = rdata_q;
        err_d   = err_q;
        ack_d   = acc;
        if (acc) begin
            rdata_d = (APB_REQ.pwrite || !hit) ? 32'h0000_0000 : {24'h00_0000, rbyte};
            err_d   = !hit;
        end
    end

    // ****************************************************************
    // Register writes; reserved locations and bits ignore data
    // ****************************************************************
    always_comb begin
        wait_d   = wait_q;
        bypass_d = bypass_q;
        baud_d   = baud_q;
        width_d  = width_q;
        if (wr) begin
            unique case (idx)
                `RCS_IDX_RESP_WAIT: wait_d   = wbyte[`RCS_WAIT_MSB:0];
                `RCS_IDX_PARITY:    bypass_d = wbyte[`RCS_PARITY_BIT];
                `RCS_IDX_BAUD:      baud_d   = wbyte;
                `RCS_IDX_MOD_WIDTH: width_d  = wbyte;
                default: begin
                end
            endcase
        end
        // Four bits: extension plus seven reaches ten
        total_d  = {2'b00, wait_d} + `RCS_WAIT_BASE;
    end

    // Checksum result held until the engine loads a new one; read only
    always_comb begin
        csum_d = csum_q;
        done_d = done_q;
        if (CSUM_LOAD) begin
            csum_d = CSUM_VALUE;
            done_d = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            wait_q   <= `RCS_RST_WAIT_FIELD;
            total_q  <= {2'b00, `RCS_RST_WAIT_FIELD} + `RCS_WAIT_BASE;
            bypass_q <= `RCS_RST_BYPASS;
            baud_q   <= `RCS_RST_BAUD;
            width_q  <= `RCS_RST_MOD_WIDTH;
            csum_q   <= {`RCS_RST_CSUM, `RCS_RST_CSUM};
            done_q   <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            err_q    <= 1'b0;
            ack_q    <= 1'b0;
        end else begin
            wait_q   <= wait_d;
            total_q  <= total_d;
            bypass_q <= bypass_d;
            baud_q   <= baud_d;
            width_q  <= width_d;
            csum_q   <= csum_d;
            done_q   <= done_d;
            rdata_q  <= rdata_d;
            err_q    <= err_d;
            ack_q    <= ack_d;
        end
    end

    assign APB_RSP.pready  = APB_REQ.psel && APB_REQ.penable && ack_q;
    assign APB_RSP.pslverr = APB_RSP.pready && err_q;
    assign APB_RSP.prdata  = rdata_q;

    assign CHECKSUM_DONE_FLAG = done_q;

    // ****************************************************************
    // Configuration outputs
    // ****************************************************************
    assign CFG_OUT.response_wait_extension = wait_q;
    assign CFG_OUT.response_wait_total     = total_q;
    assign CFG_OUT.parity_bypass           = bypass_q;
    assign CFG_OUT.baud_exponent_factor    = baud_q[7:`RCS_EXP_LSB];
    assign CFG_OUT.baud_mantissa_factor    = baud_q[`RCS_MANT_MSB:0];
    assign CFG_OUT.modulation_width_value  = width_q;

    // ****************************************************************
    // Parity path
    // ****************************************************************
    assign TX_PARITY_EN        = !bypass_q;
    assign TX_PARITY_OUT       = bypass_q ? 1'b0 : TX_PARITY_IN;
    assign RX_PARITY_ERROR     = RX_PARITY_STROBE && !bypass_q
                                 && (RX_PARITY_BIT != RX_PARITY_EXPECT);
    assign RX_EXTRA_DATA_VALID = RX_PARITY_STROBE && bypass_q;
    assign RX_EXTRA_DATA_BIT   = bypass_q ? RX_PARITY_BIT : 1'b0;

    // ****************************************************************
    // Modulation pulse; limit to half a bit period is software's duty
    // ****************************************************************
    rcs_mod_pulse u_mod_pulse (
        .clk   (CLK),
        .reset (RESET),
        .start (MOD_START),
        .width (width_q),
        .pulse (MOD_PULSE)
    );

endmodule

// file: hdl/rcs_cfg.svh
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH

// ********************************************************************
// Register indices (byte address = 4 * index)
// ********************************************************************
`define RCS_IDX_RESP_WAIT     8'h1C
`define RCS_IDX_PARITY        8'h1D
`define RCS_IDX_RSVD_A        8'h1E
`define RCS_IDX_BAUD          8'h1F
`define RCS_IDX_RSVD_B        8'h20
`define RCS_IDX_CSUM_HIGH     8'h21
`define RCS_IDX_CSUM_LOW      8'h22
`define RCS_IDX_RSVD_C        8'h23
`define RCS_IDX_MOD_WIDTH     8'h24
`define RCS_IDX_RSVD_D        8'h25

// ********************************************************************
// Reset values
// ********************************************************************
`define RCS_RST_RESP_WAIT     8'h62
`define RCS_RST_PARITY        8'h00
`define RCS_RST_RSVD_A        8'h00
`define RCS_RST_BAUD          8'hEB
`define RCS_RST_RSVD_B        8'h00
`define RCS_RST_CSUM          8'hFF
`define RCS_RST_RSVD_C        8'h88
`define RCS_RST_MOD_WIDTH     8'h26
`define RCS_RST_RSVD_D        8'h87
`define RCS_RST_WAIT_FIELD    2'h2
`define RCS_RST_WAIT_RSVD     6'h18
`define RCS_RST_BYPASS        1'b0

// ********************************************************************
// Field positions and constants
// ********************************************************************
`define RCS_WAIT_MSB          1
`define RCS_PARITY_BIT        4
`define RCS_EXP_LSB           5
`define RCS_MANT_MSB          4
`define RCS_WAIT_BASE         4'h7

`endif

// file: hdl/rcs_pkg.sv
package rcs_pkg;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [9:0] paddr;
        logic [31:0] pwdata;
    } rcs_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } rcs_apb_rsp_t;

    typedef struct packed {
        logic [1:0] response_wait_extension;
        logic [3:0] response_wait_total;
        logic       parity_bypass;
        logic [2:0] baud_exponent_factor;
        logic [4:0] baud_mantissa_factor;
        logic [7:0] modulation_width_value;
    } rcs_cfg_out_t;

    typedef enum logic [1:0] {
        RCS_PH_IDLE  = 2'b00,
        RCS_PH_PULSE = 2'b01
    } rcs_mod_state_t;

endpackage

// file: hdl/rcs_mod_pulse.sv
`timescale 1ns/1ps
`include "rcs_cfg.svh"

// ********************************************************************
// Modulation pulse timer: width + 1 carrier periods
// ********************************************************************
module rcs_mod_pulse (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Control
    input  wire logic       start,
    input  wire logic [7:0] width,
    // Output
    output logic            pulse
);
    import rcs_pkg::*;

    rcs_mod_state_t state_q;
    rcs_mod_state_t state_d;
    logic [7:0]     cnt_q;
    logic [7:0]     cnt_d;
    logic           pulse_q;
    logic           pulse_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        pulse_d = pulse_q;
        unique case (state_q)
            RCS_PH_IDLE: begin
                if (start) begin
                    state_d = RCS_PH_PULSE;
                    cnt_d   = width;
                    pulse_d = 1'b1;
                end
            end
            RCS_PH_PULSE: begin
                // Width taken at start; later writes affect the next pulse only
                if (cnt_q == 8'h00) begin
                    state_d = RCS_PH_IDLE;
                    pulse_d = 1'b0;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= RCS_PH_IDLE;
            cnt_q   <= 8'h00;
            pulse_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse = pulse_q;

endmodule

// file: tb/rcs_reader_config_regs_sva.sv
`timescale 1ns/1ps
module rcs_reader_config_regs_sva (
    // Clock and reset
    input wire logic                  CLK,
    input wire logic                  RESET,
    // Watched ports
    input wire rcs_pkg::rcs_apb_req_t APB_REQ,
    input wire logic                  CSUM_LOAD,
    input wire logic                  CHECKSUM_DONE_FLAG,
    input wire logic                  TX_PARITY_EN,
    input wire logic                  TX_PARITY_OUT,
    input wire logic                  RX_PARITY_BIT,
    input wire logic                  RX_PARITY_STROBE,
    input wire logic                  RX_PARITY_ERROR,
    input wire logic                  RX_EXTRA_DATA_VALID,
    input wire logic                  RX_EXTRA_DATA_BIT,
    input wire logic                  MOD_START,
    input wire logic                  MOD_PULSE,
    input wire rcs_pkg::rcs_cfg_out_t CFG_OUT
);
    import rcs_pkg::*;
    logic [8:0] run_q;
    logic [8:0] run_d;
    logic       wr_setup;
    // Length of the current modulation pulse
    always_comb begin
        run_d = MOD_PULSE ? run_q + 9'h1 : 9'h0;
    end
    always_ff @(posedge CLK) begin
        run_q <= RESET ? 9'h0 : run_d;
    end
    assign wr_setup = APB_REQ.psel && !APB_REQ.penable && APB_REQ.pwrite;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    chk_wait_sum: assert property (CFG_OUT.response_wait_total ==
        {2'b00, CFG_OUT.response_wait_extension} + 4'h7) else $error("wait total wrong");
    chk_tx_bypass: assert property (CFG_OUT.parity_bypass |->
        !TX_PARITY_EN && !TX_PARITY_OUT) else $error("tx parity not bypassed");
    chk_rx_nocheck: assert property (CFG_OUT.parity_bypass |-> !RX_PARITY_ERROR)
        else $error("parity checked while bypassed");
    chk_rx_passon: assert property (RX_PARITY_STROBE && CFG_OUT.parity_bypass |->
        RX_EXTRA_DATA_VALID && RX_EXTRA_DATA_BIT == RX_PARITY_BIT)
        else $error("parity bit not passed on");
    chk_bypass_wr: assert property (wr_setup && APB_REQ.paddr == 10'h074 |->
        ##2 CFG_OUT.parity_bypass == $past(APB_REQ.pwdata[4], 2))
        else $error("bypass write lost");
    chk_width_wr: assert property (wr_setup && APB_REQ.paddr == 10'h090 |->
        ##2 CFG_OUT.modulation_width_value == $past(APB_REQ.pwdata[7:0], 2))
        else $error("width write lost");
    chk_pulse_len: assert property ($fell(MOD_PULSE) |->
        run_q == {1'b0, CFG_OUT.modulation_width_value} + 9'h1)
        else $error("pulse length wrong");
    chk_pulse_cause: assert property ($rose(MOD_PULSE) |-> $past(MOD_START))
        else $error("pulse without start");
    chk_done_load: assert property (CSUM_LOAD |=> CHECKSUM_DONE_FLAG [*3])
        else $error("done flag not set");
endmodule

bind rcs_reader_config_regs rcs_reader_config_regs_sva u_rcs_reader_config_regs_sva (
    .CLK(CLK), .RESET(RESET), .APB_REQ(APB_REQ), .CSUM_LOAD(CSUM_LOAD),
    .CHECKSUM_DONE_FLAG(CHECKSUM_DONE_FLAG), .TX_PARITY_EN(TX_PARITY_EN),
    .TX_PARITY_OUT(TX_PARITY_OUT), .RX_PARITY_BIT(RX_PARITY_BIT),
    .RX_PARITY_STROBE(RX_PARITY_STROBE), .RX_PARITY_ERROR(RX_PARITY_ERROR),
    .RX_EXTRA_DATA_VALID(RX_EXTRA_DATA_VALID), .RX_EXTRA_DATA_BIT(RX_EXTRA_DATA_BIT),
    .MOD_START(MOD_START), .MOD_PULSE(MOD_PULSE), .CFG_OUT(CFG_OUT));

// file: tb/tb_reader_config_register_slice.sv
`timescale 1ns/1ps
module tb_reader_config_register_slice;
    import rcs_pkg::*;
    logic         CLK = 1'b0;
    logic         RESET = 1'b1;
    rcs_apb_req_t APB_REQ = '0;
    rcs_apb_rsp_t APB_RSP;
    rcs_apb_rsp_t rsp_s;
    logic         CSUM_LOAD = 1'b0;
    logic [15:0]  CSUM_VALUE = 16'h0;
    logic         TX_PARITY_IN = 1'b1;
    logic         RX_PARITY_BIT = 1'b0;
    logic         RX_PARITY_STROBE = 1'b0;
    logic         RX_PARITY_EXPECT = 1'b0;
    logic         MOD_START = 1'b0;
    logic         CHECKSUM_DONE_FLAG, TX_PARITY_EN, TX_PARITY_OUT, RX_PARITY_ERROR;
    logic         RX_EXTRA_DATA_VALID, RX_EXTRA_DATA_BIT, MOD_PULSE;
    rcs_cfg_out_t CFG_OUT;
    int           failures = 0;
    int           samples_checked = 0;
    int           cyc = 0;
    int           n;
    logic [7:0]   rd;
    logic         er;
    // Byte address, write data, read after reset, read after write
    logic [33:0]  rows [10] = '{
        {10'h070, 8'hFF, 8'h62, 8'h63},
        {10'h074, 8'hFF, 8'h00, 8'h10},
        {10'h078, 8'hFF, 8'h00, 8'h00},
        {10'h07C, 8'h5A, 8'hEB, 8'h5A},
        {10'h080, 8'hFF, 8'h00, 8'h00},
        {10'h084, 8'h12, 8'hFF, 8'hFF},
        {10'h088, 8'h34, 8'hFF, 8'hFF},
        {10'h08C, 8'h00, 8'h88, 8'h88},
        {10'h090, 8'h05, 8'h26, 8'h05},
        {10'h094, 8'h00, 8'h87, 8'h87}};

    rcs_reader_config_regs u_rcs_reader_config_regs (
        .CLK(CLK), .RESET(RESET), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
        .CSUM_LOAD(CSUM_LOAD), .CSUM_VALUE(CSUM_VALUE),
        .CHECKSUM_DONE_FLAG(CHECKSUM_DONE_FLAG), .TX_PARITY_IN(TX_PARITY_IN),
        .TX_PARITY_EN(TX_PARITY_EN), .TX_PARITY_OUT(TX_PARITY_OUT),
        .RX_PARITY_BIT(RX_PARITY_BIT), .RX_PARITY_STROBE(RX_PARITY_STROBE),
        .RX_PARITY_EXPECT(RX_PARITY_EXPECT), .RX_PARITY_ERROR(RX_PARITY_ERROR),
        .RX_EXTRA_DATA_VALID(RX_EXTRA_DATA_VALID), .RX_EXTRA_DATA_BIT(RX_EXTRA_DATA_BIT),
        .MOD_START(MOD_START), .MOD_PULSE(MOD_PULSE), .CFG_OUT(CFG_OUT));

    initial forever #20 CLK = ~CLK;
    // Inputs move only at rising edges, so this is what the edge samples
    always @(negedge CLK) rsp_s = APB_RSP;
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            results();
        end
    end

    task automatic results();
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h0, got}, {7'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
                       output logic [7:0] r, output logic e);
        @(posedge CLK);
        APB_REQ <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge CLK);
        APB_REQ.penable <= 1'b1;
        do @(posedge CLK); while (rsp_s.pready !== 1'b1);
        r = rsp_s.prdata[7:0];
        e = rsp_s.pslverr;
        APB_REQ <= '0;
    endtask

    initial begin
        repeat (4) @(posedge CLK);
        RESET <= 1'b0;
        @(negedge CLK);
        chk_byte({5'h0, CFG_OUT.baud_exponent_factor}, 8'h07);
        chk_byte({3'h0, CFG_OUT.baud_mantissa_factor}, 8'h0B);
        chk_byte({4'h0, CFG_OUT.response_wait_total}, 8'h09);
        chk_bit(CHECKSUM_DONE_FLAG, 1'b0);
        foreach (rows[i]) begin
            apb(1'b0, rows[i][33:24], 8'h00, rd, er);
            chk_byte(rd, rows[i][15:8]);
            chk_bit(er, 1'b0);
        end
        foreach (rows[i]) begin
            apb(1'b1, rows[i][33:24], rows[i][23:16], rd, er);
            apb(1'b0, rows[i][33:24], 8'h00, rd, er);
            chk_byte(rd, rows[i][7:0]);
        end
        chk_byte({5'h0, CFG_OUT.baud_exponent_factor}, 8'h02);
        chk_byte({3'h0, CFG_OUT.baud_mantissa_factor}, 8'h1A);
        chk_byte({4'h0, CFG_OUT.response_wait_total}, 8'h0A);
        @(posedge CLK);
        RX_PARITY_STROBE <= 1'b1;
        RX_PARITY_BIT <= 1'b1;
        @(negedge CLK);
        chk_bit(RX_PARITY_ERROR, 1'b0);
        chk_bit(TX_PARITY_EN, 1'b0);
        chk_bit(RX_EXTRA_DATA_VALID, 1'b1);
        chk_bit(RX_EXTRA_DATA_BIT, 1'b1);
        apb(1'b1, 10'h074, 8'h00, rd, er);
        @(negedge CLK);
        chk_bit(RX_PARITY_ERROR, 1'b1);
        chk_bit(TX_PARITY_OUT, 1'b1);
        chk_bit(RX_EXTRA_DATA_VALID, 1'b0);
        chk_bit(RX_EXTRA_DATA_BIT, 1'b0);
        chk_bit(TX_PARITY_EN, 1'b1);
        @(posedge CLK);
        CSUM_VALUE <= 16'hBE5A;
        CSUM_LOAD <= 1'b1;
        TX_PARITY_IN <= 1'b0;
        RX_PARITY_EXPECT <= 1'b1;
        @(negedge CLK);
        chk_bit(TX_PARITY_OUT, 1'b0);
        chk_bit(RX_PARITY_ERROR, 1'b0);
        chk_bit(CHECKSUM_DONE_FLAG, 1'b0);
        @(posedge CLK);
        CSUM_LOAD <= 1'b0;
        apb(1'b0, 10'h084, 8'h00, rd, er);
        chk_byte(rd, 8'hBE);
        apb(1'b0, 10'h088, 8'h00, rd, er);
        chk_byte(rd, 8'h5A);
        chk_bit(CHECKSUM_DONE_FLAG, 1'b1);
        apb(1'b0, 10'h098, 8'h00, rd, er);
        chk_bit(er, 1'b1);
        apb(1'b0, 10'h071, 8'h00, rd, er);
        chk_bit(er, 1'b1);
        chk_byte(rd, 8'h00);
        @(posedge CLK);
        MOD_START <= 1'b1;
        @(posedge CLK);
        MOD_START <= 1'b0;
        n = 0;
        repeat (12) begin
            @(negedge CLK);
            n += int'(MOD_PULSE === 1'b1);
        end
        chk_byte(8'(n), 8'h06);
        @(posedge CLK);
        RESET <= 1'b1;
        repeat (4) @(posedge CLK);
        RESET <= 1'b0;
        apb(1'b0, 10'h090, 8'h00, rd, er);
        chk_byte(rd, 8'h26);
        chk_bit(CHECKSUM_DONE_FLAG, 1'b0);
        chk_byte({4'h0, CFG_OUT.response_wait_total}, 8'h09);
        results();
    end
endmodule
